// file: ddr_mode_decode.v
// command decoder and extended mode register functions of a ddr device
// assumes all command pins and the device clock pin come from outside the clk_in domain
`include "ddr_consts.vh"
module ddr_mode_decode #(
	parameter IS_X8 = 1'b1
) (
	input  wire               clk_in,
	input  wire               rst_n_in,
	input  wire               dev_clk_in,
	input  wire               cke_in,
	input  wire               cs_n_in,
	input  wire               ras_n_in,
	input  wire               cas_n_in,
	input  wire               we_n_in,
	input  wire [1:0]         bank_in,
	input  wire [`ADDR_W-1:0] addr_in,
	input  wire               on_die_termination_in,
	input  wire               exec_ready_in,
	output reg  [`CMD_W-1:0]  exec_cmd_out,
	output reg  [1:0]         exec_bank_out,
	output reg  [`ADDR_W-1:0] exec_addr_out,
	output reg                exec_valid_out,
	output reg                cmd_ready_out,
	output reg                dll_on_out,
	output reg                dll_reset_out,
	output reg                dll_locked_out,
	output reg                reduced_drive_out,
	output reg                strobe_n_oe_out,
	output reg                dup_strobe_oe_out,
	output reg                dup_strobe_n_oe_out,
	output reg                data_out_en_out,
	output reg  [1:0]         termination_resistance_out,
	output reg                termination_on_out,
	output reg  [`LAT_W-1:0]  total_read_latency_out,
	output reg  [`LAT_W-1:0]  total_write_latency_out,
	output reg                self_refresh_out,
	output reg                power_down_out,
	output reg  [`ADDR_W-1:0] extended_mode_register_two_out,
	output reg  [`ADDR_W-1:0] extended_mode_register_three_out
);
	localparam ST_ACTIVE = 2'h0;
	localparam ST_PDOWN  = 2'h1;
	localparam ST_SREF   = 2'h2;

	// three stage sync on the device clock: two for metastability, third for edge detect; other pins get two stages
	reg [2:0]         dclk_q;
	reg [1:0]         cke_s_q;
	reg [1:0]         cs_s_q;
	reg [1:0]         ras_s_q;
	reg [1:0]         cas_s_q;
	reg [1:0]         we_s_q;
	reg [1:0]         odt_s_q;
	reg [1:0]         ba0_s_q;
	reg [1:0]         ba1_s_q;
	reg [`ADDR_W-1:0] a_m_q;
	reg [`ADDR_W-1:0] a_s_q;
	reg               cke_prev_q;
	reg [1:0]         state_q;
	reg [`ADDR_W-1:0] mode_register_q;
	reg [`ADDR_W-1:0] extended_mode_register_q;
	reg [7:0]         lock_cnt_q;
	reg [`FIFO_W-1:0] pipe_q [0:`PIPE_DEPTH-1];
	reg [`PIPE_DEPTH-1:0] pipe_v_q;
	reg [`FIFO_W-1:0] tap_word_q;
	reg               tap_v_q;

	wire dclk_rise = dclk_q[1] && !dclk_q[2];
	wire cke_now   = cke_s_q[1];
	wire cke_fall  = cke_prev_q && !cke_now;
	wire cke_hold  = cke_prev_q && cke_now;

	// chip select low: row, column, write strobes form the code
	function [`CMD_W-1:0] decode_cmd;
		input cs_n;
		input ras_n;
		input cas_n;
		input we_n;
		begin
			if (cs_n) begin
				decode_cmd = `CMD_NOP;
			end else begin
				decode_cmd = {ras_n, cas_n, we_n};
			end
		end
	endfunction

	// plain binary latency with reserved codes clamped to the maximum
	function [2:0] al_of;
		input [`ADDR_W-1:0] e;
		begin
			if (e[`AL_HI:`AL_LO] > `AL_MAX) begin
				al_of = `AL_MAX;
			end else begin
				al_of = e[`AL_HI:`AL_LO];
			end
		end
	endfunction

	wire [`CMD_W-1:0] cmd_now = decode_cmd(cs_s_q[1], ras_s_q[1], cas_s_q[1], we_s_q[1]);
	wire [1:0]        ba_now  = {ba1_s_q[1], ba0_s_q[1]};
	wire              nop_now = (cmd_now == `CMD_NOP);
	wire [2:0]        al_now  = al_of(extended_mode_register_q);
	wire [2:0]        cl_now  = mode_register_q[`CL_HI:`CL_LO];

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			dclk_q  <= 3'h0;
			cke_s_q <= 2'h0;
			cs_s_q  <= 2'h3;
			ras_s_q <= 2'h3;
			cas_s_q <= 2'h3;
			we_s_q  <= 2'h3;
			odt_s_q <= 2'h0;
			ba0_s_q <= 2'h0;
			ba1_s_q <= 2'h0;
			a_m_q   <= {`ADDR_W{1'b0}};
			a_s_q   <= {`ADDR_W{1'b0}};
		end else begin
			dclk_q  <= {dclk_q[1:0], dev_clk_in};
			cke_s_q <= {cke_s_q[0], cke_in};
			cs_s_q  <= {cs_s_q[0], cs_n_in};
			ras_s_q <= {ras_s_q[0], ras_n_in};
			cas_s_q <= {cas_s_q[0], cas_n_in};
			we_s_q  <= {we_s_q[0], we_n_in};
			odt_s_q <= {odt_s_q[0], on_die_termination_in};
			ba0_s_q <= {ba0_s_q[0], bank_in[0]};
			ba1_s_q <= {ba1_s_q[0], bank_in[1]};
			a_m_q   <= addr_in;
			a_s_q   <= a_m_q;
		end
	end

	// power state machine, advanced on each device clock rising edge
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q    <= ST_ACTIVE;
			cke_prev_q <= 1'b0;
		end else if (dclk_rise) begin
			cke_prev_q <= cke_now;
			case (state_q)
				ST_ACTIVE: begin
					if (cke_fall && cmd_now == `CMD_REFRESH) begin
						state_q <= ST_SREF;
					end else if (cke_fall && nop_now) begin
						state_q <= ST_PDOWN;
					end
				end
				// no refresh while here; the controller bounds the stay
				ST_PDOWN: begin
					if (cke_now && nop_now) begin
						state_q <= ST_ACTIVE;
					end
				end
				// exit on cke alone; real part exits asynchronously
				ST_SREF: begin
					if (cke_now) begin
						state_q <= ST_ACTIVE;
					end
				end
				default: begin
					state_q <= ST_ACTIVE;
				end
			endcase
		end
	end

	// commands count only with clock enable high at this edge and the one before
	wire cmd_valid = dclk_rise && cke_hold && (state_q == ST_ACTIVE);
	wire load_now  = cmd_valid && (cmd_now == `CMD_LOAD);
	wire sref_exit = dclk_rise && (state_q == ST_SREF) && cke_now;
	wire dll_reset_req = sref_exit ||
		(load_now && ba_now == `SEL_BASE && a_s_q[`BIT_DLL_RESET]);

	// mode registers; contents survive everything but reset or reload
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode_register_q                  <= {`ADDR_W{1'b0}};
			extended_mode_register_q         <= {`ADDR_W{1'b0}};
			extended_mode_register_two_out   <= {`ADDR_W{1'b0}};
			extended_mode_register_three_out <= {`ADDR_W{1'b0}};
		end else if (load_now) begin
			if (ba_now == `SEL_BASE) begin
				mode_register_q <= a_s_q;
			end else if (ba_now == `SEL_EXT) begin
				extended_mode_register_q <= a_s_q;
			end else if (ba_now == `SEL_EXT2) begin
				extended_mode_register_two_out <= a_s_q;
			end else begin
				extended_mode_register_three_out <= a_s_q;
			end
		end
	end

	// dll reset pulses on base register reset bit or self refresh exit
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			dll_reset_out  <= 1'b0;
			lock_cnt_q     <= 8'h0;
			dll_locked_out <= 1'b0;
		end else begin
			dll_reset_out <= dll_reset_req;
			if (dll_reset_out) begin
				lock_cnt_q     <= 8'h0;
				dll_locked_out <= 1'b0;
			end else if (dclk_rise && !dll_locked_out) begin
				// counts device clocks; lock flag shows when reads are safe
				if (lock_cnt_q == `DLL_LOCK_CYCLES - 8'h1) begin
					dll_locked_out <= 1'b1;
				end
				lock_cnt_q <= lock_cnt_q + 8'h1;
			end
		end
	end

	// read and write commands held al device clocks in a delay line
	// full address rides along; bit 10 is auto precharge or all banks
	wire [`FIFO_W-1:0] cmd_word = {cmd_now, ba_now, a_s_q};
	wire               is_rw    = (cmd_now == `CMD_READ) || (cmd_now == `CMD_WRITE);
	wire               fifo_in_ready;
	wire [`FIFO_W-1:0] fifo_out_data;
	wire               fifo_out_valid;
	wire               cur_push  = cmd_valid && !nop_now && (!is_rw || al_now == 3'h0);
	// a held command leaves one clock after the rise, so it never meets a fresh one
	wire [`FIFO_W-1:0] push_data = tap_v_q ? tap_word_q : cmd_word;
	wire               push_v    = cur_push || tap_v_q;

	genvar gi;
	generate
		for (gi = 0; gi < `PIPE_DEPTH; gi = gi + 1) begin : g_pipe
			if (gi == 0) begin : g_head
				always @(posedge clk_in) begin
					if (!rst_n_in) begin
						pipe_v_q[gi] <= 1'b0;
						pipe_q[gi]   <= {`FIFO_W{1'b0}};
					end else if (dclk_rise) begin
						pipe_v_q[gi] <= cmd_valid && is_rw && (al_now != 3'h0);
						pipe_q[gi]   <= cmd_word;
					end
				end
			end else begin : g_tail
				always @(posedge clk_in) begin
					if (!rst_n_in) begin
						pipe_v_q[gi] <= 1'b0;
						pipe_q[gi]   <= {`FIFO_W{1'b0}};
					end else if (dclk_rise) begin
						pipe_v_q[gi] <= pipe_v_q[gi-1];
						pipe_q[gi]   <= pipe_q[gi-1];
					end
				end
			end
		end
	endgenerate

	// tap at the programmed latency; retuning it with commands in flight mis-times them
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			tap_v_q    <= 1'b0;
			tap_word_q <= {`FIFO_W{1'b0}};
		end else begin
			tap_v_q    <= dclk_rise && (al_now != 3'h0) && pipe_v_q[al_now - 3'h1];
			tap_word_q <= pipe_q[al_now - 3'h1];
		end
	end

	// queue absorbs a stalled core; a full queue drops commands, flagged by cmd_ready_out
	cmd_fifo #(
		.WIDTH(`FIFO_W),
		.DEPTH(`FIFO_DEPTH),
		.AW   (`FIFO_AW)
	) u_fifo (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.wr_data_in  (push_data),
		.wr_valid_in (push_v),
		.wr_ready_out(fifo_in_ready),
		.rd_data_out (fifo_out_data),
		.rd_valid_out(fifo_out_valid),
		.rd_ready_in (exec_ready_in && !exec_valid_out)
	);

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			exec_valid_out <= 1'b0;
			exec_cmd_out   <= `CMD_NOP;
			exec_bank_out  <= 2'h0;
			exec_addr_out  <= {`ADDR_W{1'b0}};
			cmd_ready_out  <= 1'b0;
		end else begin
			cmd_ready_out <= fifo_in_ready;
			if (exec_valid_out) begin
				exec_valid_out <= 1'b0;
			end else if (exec_ready_in && fifo_out_valid) begin
				exec_valid_out <= 1'b1;
				exec_cmd_out   <= fifo_out_data[`FIFO_W-1:`FIFO_W-3];
				exec_bank_out  <= fifo_out_data[`FIFO_W-4:`FIFO_W-5];
				exec_addr_out  <= fifo_out_data[`ADDR_W-1:0];
			end
		end
	end

	// output controls derived from the base and extended registers, the termination pin and power state
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			dll_on_out                 <= 1'b0;
			reduced_drive_out          <= 1'b0;
			strobe_n_oe_out            <= 1'b0;
			dup_strobe_oe_out          <= 1'b0;
			dup_strobe_n_oe_out        <= 1'b0;
			data_out_en_out            <= 1'b0;
			termination_resistance_out <= 2'h0;
			termination_on_out         <= 1'b0;
			total_read_latency_out     <= 4'h0;
			total_write_latency_out    <= 4'h0;
			self_refresh_out           <= 1'b0;
			power_down_out             <= 1'b0;
		end else begin
			self_refresh_out <= (state_q == ST_SREF);
			power_down_out   <= (state_q == ST_PDOWN);
			dll_on_out <= !extended_mode_register_q[`BIT_DLL_OFF] && (state_q != ST_SREF);
			reduced_drive_out <= extended_mode_register_q[`BIT_DRIVE];
			data_out_en_out   <= !extended_mode_register_q[`BIT_OUT_OFF];
			// enables only gate the buffers; strobe timing belongs to the data path
			strobe_n_oe_out   <= !extended_mode_register_q[`BIT_STROBE_N] &&
				!extended_mode_register_q[`BIT_OUT_OFF];
			dup_strobe_oe_out <= IS_X8 && extended_mode_register_q[`BIT_DUP_STROBE] &&
				!extended_mode_register_q[`BIT_OUT_OFF];
			dup_strobe_n_oe_out <= IS_X8 && extended_mode_register_q[`BIT_DUP_STROBE] &&
				!extended_mode_register_q[`BIT_STROBE_N] &&
				!extended_mode_register_q[`BIT_OUT_OFF];
			// 00 off, 01 75 ohm, 10 150 ohm, 11 reserved
			termination_resistance_out <= {extended_mode_register_q[`BIT_TERM_B],
				extended_mode_register_q[`BIT_TERM_A]};
			termination_on_out <= odt_s_q[1] && (state_q != ST_SREF) &&
				(extended_mode_register_q[`BIT_TERM_A] ||
				extended_mode_register_q[`BIT_TERM_B]);
			total_read_latency_out  <= {1'b0, al_now} + {1'b0, cl_now};
			total_write_latency_out <= {1'b0, al_now} + {1'b0, cl_now} - 4'h1;
		end
	end
endmodule // ddr_mode_decode

// file: ddr_consts.vh
// constants for the extended mode and command decode block of a four-bank ddr device
// assumes the controller samples commands on the device clock, which arrives as a pin input
`ifndef DDR_CONSTS_VH
`define DDR_CONSTS_VH
`define ADDR_W 14
`define CMD_W 3
`define CMD_LOAD 3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE 3'h3
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5
`define CMD_NOP 3'h7
`define SEL_BASE 2'h0
`define SEL_EXT 2'h1
`define SEL_EXT2 2'h2
`define SEL_EXT3 2'h3
`define BIT_DLL_OFF 0
`define BIT_DRIVE 1
`define BIT_TERM_A 2
`define AL_LO 3
`define AL_HI 5
`define BIT_TERM_B 6
`define BIT_AP 10
`define BIT_STROBE_N 10
`define BIT_DUP_STROBE 11
`define BIT_OUT_OFF 12
`define CL_LO 4
`define CL_HI 6
`define BIT_DLL_RESET 8
`define AL_MAX 3'h4
`define CL_DEFAULT 3'h3
`define LAT_W 4
`define PIPE_DEPTH 8
`define DLL_LOCK_CYCLES 8'hC8
`define FIFO_W 19
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// file: cmd_fifo.v
// small synchronous fifo with valid and ready on both sides
// assumes one clock and synchronous active low reset
module cmd_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	output wire [WIDTH-1:0] rd_data_out,
	output wire             rd_valid_out,
	input  wire             rd_ready_in
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wp_q;
	reg [AW:0]      rp_q;
	wire            full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire            empty = (wp_q == rp_q);
	wire            push  = wr_valid_in && !full;
	wire            pop   = rd_ready_in && !empty;

	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign rd_data_out  = mem[rp_q[AW-1:0]];

	always @(posedge clk_in) begin
		if (push) begin
			mem[wp_q[AW-1:0]] <= wr_data_in;
		end
	end

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule // cmd_fifo

// file: ctrl_model.sv
// memory controller model: device clock, clock enable, command, bank and address pins
// assumes the bench calls send from one process, one command at a time
module ctrl_model (
	input  wire         clk_in,
	output logic        dev_clk_out,
	output logic        cke_out,
	output logic        cs_n_out,
	output logic        ras_n_out,
	output logic        cas_n_out,
	output logic        we_n_out,
	output logic [1:0]  bank_out,
	output logic [13:0] addr_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int lock_cnt = 0;
	initial begin
		dev_clk_out = 1'b0;
		cke_out = 1'b0;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
		bank_out = 2'h0;
		addr_out = 14'h0000;
	end
	// runs free like the real clock pair, eight clk_in periods long and in fixed phase to clk_in
	always #100 dev_clk_out = ~dev_clk_out;
	task automatic drive(input logic c, input logic [2:0] cmd, input logic [1:0] b,
		input logic [13:0] a);
		@(negedge dev_clk_out);
		@(posedge clk_in);
		#1;
		cke_out = c;
		cs_n_out = 1'b0;
		{ras_n_out, cas_n_out, we_n_out} = cmd;
		bank_out = b;
		addr_out = a;
		lock_cnt++;
		@(posedge dev_clk_out);
	endtask
	task automatic send(input logic c, input logic [2:0] cmd, input logic [1:0] b,
		input logic [13:0] a);
		while (cmd == 3'h5 && lock_cnt < 200)
			drive(cke_out, 3'h7, b, ~a);
		if ((cmd == 3'h0 && b == 2'h0 && a[8]) || (c && !cke_out))
			lock_cnt = 0;
		drive(c, cmd, b, a);
		// only nops follow, so no burst is cut and the load delay passes
		repeat (5) drive(c, 3'h7, b, ~a);
	endtask
endmodule // ctrl_model

// file: mode_decode_sva.sv
// assertions on the ports of the mode decoder
// assumes clk_in and a synchronous active low rst_n_in
module mode_decode_sva (
	input wire       clk_in,
	input wire       rst_n_in,
	input wire       on_die_termination_in,
	input wire       exec_valid_out,
	input wire       dll_on_out,
	input wire       dll_reset_out,
	input wire       strobe_n_oe_out,
	input wire       dup_strobe_oe_out,
	input wire       dup_strobe_n_oe_out,
	input wire       data_out_en_out,
	input wire [1:0] termination_resistance_out,
	input wire       termination_on_out,
	input wire [3:0] total_read_latency_out,
	input wire [3:0] total_write_latency_out,
	input wire       self_refresh_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_sr_dll_off: assert property ($rose(self_refresh_out) |-> ##[0:2] !dll_on_out)
		else $error("dll left on in self refresh");
	chk_sr_exit_reset: assert property ($fell(self_refresh_out) |-> $past(dll_reset_out))
		else $error("no dll reset on self refresh exit");
	chk_strobe_pair: assert property (dup_strobe_n_oe_out |-> dup_strobe_oe_out && strobe_n_oe_out)
		else $error("read strobe complement without its pair");
	chk_out_off: assert property (!data_out_en_out |-> !(strobe_n_oe_out || dup_strobe_oe_out))
		else $error("strobe driven with outputs disabled");
	chk_wl_rl: assert property ($past(rst_n_in, 2)
		|-> total_write_latency_out == total_read_latency_out - 4'h1) else $error("write latency");
	chk_term_sr: assert property (self_refresh_out && $past(self_refresh_out) |-> !termination_on_out)
		else $error("termination on in self refresh");
	chk_term_pin: assert property (!on_die_termination_in [*6] |-> !termination_on_out)
		else $error("termination on with pin low");
	chk_term_res: assert property (termination_resistance_out == 2'h0
		&& $past(termination_resistance_out) == 2'h0 |-> !termination_on_out) else $error("rtt off");
	chk_exec_pulse: assert property (exec_valid_out |=> !exec_valid_out)
		else $error("exec valid longer than one cycle");
endmodule // mode_decode_sva

// file: ddr_mode_decode_tb_top.sv
// bench for the extended mode and command decoder
// assumes ctrl_model drives the command pins; the checker is bound at the foot
module ddr_mode_decode_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        on_die_termination_in = 1'b0;
	logic        exec_ready_in = 1'b1;
	wire         dev_clk_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
	wire  [1:0]  bank_in, exec_bank_out, termination_resistance_out;
	wire  [13:0] addr_in, exec_addr_out, extended_mode_register_two_out;
	wire  [13:0] extended_mode_register_three_out;
	wire  [2:0]  exec_cmd_out;
	wire  [3:0]  total_read_latency_out, total_write_latency_out;
	wire         exec_valid_out, cmd_ready_out, dll_on_out, dll_reset_out, dll_locked_out;
	wire         reduced_drive_out, strobe_n_oe_out, dup_strobe_oe_out, dup_strobe_n_oe_out;
	wire         data_out_en_out, termination_on_out, self_refresh_out, power_down_out;
	int          err_count = 0;
	int          cmp_count = 0;
	logic [18:0] seen[$];
	always #12.5 clk_in = ~clk_in;
	ctrl_model ctl (.clk_in, .dev_clk_out(dev_clk_in), .cke_out(cke_in), .cs_n_out(cs_n_in),
		.ras_n_out(ras_n_in), .cas_n_out(cas_n_in), .we_n_out(we_n_in), .bank_out(bank_in),
		.addr_out(addr_in));
	ddr_mode_decode dut (.clk_in, .rst_n_in, .dev_clk_in, .cke_in, .cs_n_in, .ras_n_in,
		.cas_n_in, .we_n_in, .bank_in, .addr_in, .on_die_termination_in, .exec_ready_in,
		.exec_cmd_out, .exec_bank_out, .exec_addr_out, .exec_valid_out, .cmd_ready_out,
		.dll_on_out, .dll_reset_out, .dll_locked_out, .reduced_drive_out, .strobe_n_oe_out,
		.dup_strobe_oe_out, .dup_strobe_n_oe_out, .data_out_en_out, .termination_resistance_out,
		.termination_on_out, .total_read_latency_out, .total_write_latency_out,
		.self_refresh_out, .power_down_out, .extended_mode_register_two_out,
		.extended_mode_register_three_out);
	always @(posedge clk_in)
		if (exec_valid_out === 1'b1) seen.push_back({exec_cmd_out, exec_bank_out, exec_addr_out});
	task automatic fail(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	function automatic bit differ(input logic [31:0] a, input logic [31:0] b);
		cmp_count++;
		return a !== b;
	endfunction
	task automatic final_report();
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic set_odt(input logic v);
		@(posedge clk_in);
		#1 on_die_termination_in = v;
		repeat (8) @(posedge clk_in);
	endtask
	task automatic t_ext_modes();
		logic [13:0] val [3] = '{14'h0816, 14'h1C60, 14'h0C08};
		logic [14:0] exp [3] = '{15'h7D54, 15'h0276, 15'h1443};
		logic [14:0] got;
		ctl.send(1'b1, 3'h0, 2'h0, 14'h0130);
		for (int i = 0; i < 3; i++) begin
			ctl.send(1'b1, 3'h0, 2'h1, val[i]);
			got = {reduced_drive_out, strobe_n_oe_out, dup_strobe_oe_out, dup_strobe_n_oe_out,
				data_out_en_out, termination_resistance_out, total_read_latency_out,
				total_write_latency_out};
			if (differ(got, exp[i])) fail("extended mode outputs");
		end
	endtask
	task automatic t_spare_regs();
		ctl.send(1'b1, 3'h0, 2'h2, 14'h2A5A);
		ctl.send(1'b1, 3'h0, 2'h3, 14'h15A5);
		ctl.send(1'b1, 3'h0, 2'h1, 14'h0004);
		ctl.send(1'b1, 3'h0, 2'h0, 14'h0030);
		if (differ({extended_mode_register_two_out, extended_mode_register_three_out},
			{14'h2A5A, 14'h15A5})) fail("spare registers");
	endtask
	task automatic t_decode_fifo();
		logic [18:0] cmds [5] = '{{3'h2, 2'h1, 14'h0400}, {3'h3, 2'h2, 14'h1234},
			{3'h4, 2'h3, 14'h0404}, {3'h5, 2'h0, 14'h0008}, {3'h1, 2'h0, 14'h0000}};
		int n;
		seen.delete();
		@(posedge clk_in);
		#1 exec_ready_in = 1'b0;
		foreach (cmds[i]) ctl.send(1'b1, cmds[i][18:16], cmds[i][15:14], cmds[i][13:0]);
		for (int i = 0; i < 13; i++) ctl.send(1'b1, 3'h3, 2'h1, 14'(i));
		if (differ(cmd_ready_out, 1'b0)) fail("queue never full");
		@(posedge clk_in);
		#1 exec_ready_in = 1'b1;
		for (n = 0; n < 200 && seen.size() < 16; n++) @(posedge clk_in);
		if (n == 200) begin
			fail("queue drain timeout");
			final_report();
		end
		repeat (40) @(posedge clk_in);
		if (differ(seen.size(), 16)) fail("queue depth");
		for (int i = 0; i < 16; i++)
			if (differ(seen[i], i < 5 ? cmds[i] : {3'h3, 2'h1, 14'(i - 5)})) fail("command");
		if (differ(dll_locked_out, 1'b1)) fail("dll lock");
	endtask
	task automatic t_posted_latency();
		ctl.send(1'b1, 3'h0, 2'h1, 14'h0010);
		set_odt(1'b1);
		if (differ({termination_on_out, total_read_latency_out, total_write_latency_out}, 9'h054))
			fail("posted latency setup");
		set_odt(1'b0);
		seen.delete();
		ctl.drive(1'b1, 3'h4, 2'h1, 14'h0523);
		repeat (2) ctl.drive(1'b1, 3'h7, 2'h0, 14'h0000);
		if (differ(seen.size(), 0)) fail("write not held");
		repeat (12) @(posedge clk_in);
		if (differ(seen.size(), 1)) fail("held write lost");
		else if (differ(seen[0], {3'h4, 2'h1, 14'h0523})) fail("held write");
		ctl.send(1'b1, 3'h0, 2'h1, 14'h0004);
	endtask
	task automatic t_low_power();
		seen.delete();
		set_odt(1'b1);
		if (differ(termination_on_out, 1'b1)) fail("termination pin on");
		ctl.send(1'b0, 3'h1, 2'h0, 14'h0000);
		ctl.send(1'b0, 3'h3, 2'h2, 14'h0055);
		if (differ({self_refresh_out, dll_on_out, termination_on_out}, 3'h4)) fail("self refresh");
		if (differ(seen.size(), 0)) fail("command taken while asleep");
		ctl.send(1'b1, 3'h7, 2'h0, 14'h0000);
		if (differ({self_refresh_out, dll_on_out}, 2'h1)) fail("self refresh exit");
		set_odt(1'b0);
		if (differ(termination_on_out, 1'b0)) fail("termination pin off");
		ctl.send(1'b0, 3'h7, 2'h0, 14'h0000);
		ctl.send(1'b0, 3'h2, 2'h1, 14'h0400);
		if (differ(power_down_out, 1'b1)) fail("power down entry");
		// brief stay, so refresh intervals still hold
		ctl.send(1'b1, 3'h7, 2'h0, 14'h0000);
		ctl.send(1'b1, 3'h3, 2'h2, 14'h0077);
		if (differ({power_down_out, 31'(seen.size())}, 32'h1)) fail("power down exit");
		else if (differ(seen[0], {3'h3, 2'h2, 14'h0077})) fail("command after wake");
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		#1;
		if (differ({exec_cmd_out, exec_valid_out, dll_on_out, data_out_en_out}, 6'h38))
			fail("reset values");
		@(posedge clk_in);
		#1 rst_n_in = 1'b1;
		ctl.send(1'b1, 3'h7, 2'h0, 14'h0000);
		t_ext_modes();
		t_spare_regs();
		t_decode_fifo();
		t_posted_latency();
		t_low_power();
		final_report();
	end
endmodule // ddr_mode_decode_tb_top
bind ddr_mode_decode mode_decode_sva chk (.clk_in, .rst_n_in, .on_die_termination_in,
	.exec_valid_out, .dll_on_out, .dll_reset_out, .strobe_n_oe_out, .dup_strobe_oe_out,
	.dup_strobe_n_oe_out, .data_out_en_out, .termination_resistance_out, .termination_on_out,
	.total_read_latency_out, .total_write_latency_out, .self_refresh_out);
